/* inc/pmbus_calc_pkg.sv */
package pmbus_calc_pkg;

  // Command codes, used as register offsets
  localparam logic [7:0] CMD_OPERATION   = 8'h01;
  localparam logic [7:0] CMD_OUTPUT_TRIM = 8'h22;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW  = 8'h26;
  localparam logic [7:0] CMD_SCALE_LOOP  = 8'h29;
  localparam logic [7:0] CMD_SENSE_GAIN  = 8'h38;
  localparam logic [7:0] CMD_SENSE_OFFS  = 8'h39;
  localparam logic [7:0] CMD_OC_FAULT    = 8'h46;
  localparam logic [7:0] CMD_OC_WARN     = 8'h4A;
  localparam logic [7:0] CMD_RISE_TIME   = 8'h61;

  // Register storage indices
  localparam int         NUM_REGS   = 10;
  localparam logic [3:0] IDX_OP     = 4'h0;
  localparam logic [3:0] IDX_TRIM   = 4'h1;
  localparam logic [3:0] IDX_MHIGH  = 4'h2;
  localparam logic [3:0] IDX_MLOW   = 4'h3;
  localparam logic [3:0] IDX_SCALE  = 4'h4;
  localparam logic [3:0] IDX_GAIN   = 4'h5;
  localparam logic [3:0] IDX_OFFS   = 4'h6;
  localparam logic [3:0] IDX_FAULT  = 4'h7;
  localparam logic [3:0] IDX_WARN   = 4'h8;
  localparam logic [3:0] IDX_RISE   = 4'h9;
  localparam logic [3:0] IDX_NONE   = 4'hF;

  // Reset values (Linear words)
  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [15:0] RST_SCALE = 16'hB900;
  localparam logic [15:0] RST_RISE  = 16'h0003;

  // Field positions
  localparam int         LIN_EXP_LSB = 11;
  localparam logic [4:0] SCALE_EXP   = 5'h17;
  localparam int         SCALE_FRAC  = 9;
  localparam int         OP_MARGIN_LSB = 4;
  localparam logic [1:0] OP_MARGIN_LOW  = 2'h1;
  localparam logic [1:0] OP_MARGIN_HIGH = 2'h2;

  // Fixed-point constants, Q16 unless noted
  localparam logic signed [63:0] BASE_REF_Q16  = 64'sh0000_0000_0000_999A;
  localparam logic signed [63:0] DEV_LIMIT_Q16 = 64'sh0000_0000_0000_2666;
  localparam logic signed [63:0] TRIM_CODE_K   = 64'sh0000_0000_0000_01AB;
  localparam logic signed [63:0] TRIM_CODE_MIN = -64'sh0000_0000_0000_0040;
  localparam logic signed [63:0] TRIM_CODE_MAX = 64'sh0000_0000_0000_003F;
  localparam logic signed [63:0] GAIN_STEP_Q16 = 64'sh0000_0000_0000_07D0;
  localparam logic signed [63:0] GAIN_RECIP_K  = 64'sh0000_0000_0000_8312;
  localparam int                 GAIN_RECIP_SH = 26;
  localparam logic signed [63:0] GAIN_CODE_MAX = 64'sh0000_0000_0000_01FF;
  localparam int                 OFFS_SHIFT    = 12;
  localparam int                 LIMIT_SHIFT   = 15;
  localparam logic signed [63:0] AMPS_MAX_Q16  = 64'sh0000_0000_007F_0000;
  localparam logic signed [63:0] ONE_Q16       = 64'sh0000_0000_0001_0000;
  localparam logic signed [63:0] TEMPCO_Q16    = 64'sh0000_0000_0000_0106;
  localparam logic signed [63:0] TEMP_REF_C    = 64'sh0000_0000_0000_0019;
  localparam logic signed [63:0] DAC_RECIP_K   = 64'sh0000_0000_0000_8889;
  localparam int                 DAC_SHIFT     = 48;
  localparam int                 RAMP_SHIFT    = 24;

  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int CYCLES_PER_MS  = CLK_HZ / MS_PER_S;

  function automatic logic [3:0] code_index(input logic [7:0] c);
    case (c)
      CMD_OPERATION:   code_index = IDX_OP;
      CMD_OUTPUT_TRIM: code_index = IDX_TRIM;
      CMD_MARGIN_HIGH: code_index = IDX_MHIGH;
      CMD_MARGIN_LOW:  code_index = IDX_MLOW;
      CMD_SCALE_LOOP:  code_index = IDX_SCALE;
      CMD_SENSE_GAIN:  code_index = IDX_GAIN;
      CMD_SENSE_OFFS:  code_index = IDX_OFFS;
      CMD_OC_FAULT:    code_index = IDX_FAULT;
      CMD_OC_WARN:     code_index = IDX_WARN;
      CMD_RISE_TIME:   code_index = IDX_RISE;
      default:         code_index = IDX_NONE;
    endcase
  endfunction

  // Linear word (5-bit exponent, 11-bit mantissa) to Q16
  function automatic logic signed [63:0] lin_to_q16(input logic [15:0] w);
    logic signed [63:0] m;
    logic signed [6:0]  s;
    m = 64'(signed'(w[10:0]));
    s = 7'(signed'(w[15:LIN_EXP_LSB])) + 7'sd16;
    lin_to_q16 = m <<< s[5:0];
  endfunction

  function automatic logic signed [63:0] clamp64(input logic signed [63:0] v,
                                                 input logic signed [63:0] lo,
                                                 input logic signed [63:0] hi);
    clamp64 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Feedback-referred value of a Q16 voltage, using a scale-loop word
  function automatic logic signed [63:0] fb_of(input logic signed [63:0] v,
                                               input logic [15:0] scale_w);
    fb_of = (v * 64'(signed'(scale_w[10:0]))) >>> SCALE_FRAC;
  endfunction

endpackage

/* inc/pmbus_cfg_if.sv */
`timescale 1ns/1ps
interface pmbus_cfg_if;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        rsp_err;

  modport host_mp (output cmd_valid, cmd_write, cmd_code, cmd_wdata,
                   input  rsp_valid, rsp_rdata, rsp_err);
  modport dev_mp  (input  cmd_valid, cmd_write, cmd_code, cmd_wdata,
                   output rsp_valid, rsp_rdata, rsp_err);
endinterface

/* verilog/setpoint_threshold_dev.sv */
`timescale 1ns/1ps
module setpoint_threshold_dev #(
  parameter int DAC_W = 8
) (
  // Clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_resetn,
  // Command side
  pmbus_cfg_if.dev_mp                  bus,
  // Die temperature, signed degrees C
  input  wire logic signed [7:0]       i_die_temp,
  // Towards the analog loop
  output logic signed [6:0]            o_ref_code,
  output logic                         o_ramping,
  output logic [1:0]                   o_margin_state,
  output logic [DAC_W-1:0]             o_oc_warn_dac,
  output logic [DAC_W-1:0]             o_oc_fault_dac
);

  localparam logic signed [63:0] DAC_MAX = 64'((1 << DAC_W) - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0] regs_q [pmbus_calc_pkg::NUM_REGS];
  logic        rsp_valid_q;
  logic [15:0] rsp_rdata_q;
  logic        rsp_err_q;

  wire  [3:0]  cmd_idx   = pmbus_calc_pkg::code_index(bus.cmd_code);
  wire         cmd_hit   = (cmd_idx != pmbus_calc_pkg::IDX_NONE);
  // A scale word with any other exponent would silently rescale the trim and margin settings
  wire         scale_bad = (cmd_idx == pmbus_calc_pkg::IDX_SCALE) &&
                           (bus.cmd_wdata[15:pmbus_calc_pkg::LIN_EXP_LSB] !=
                            pmbus_calc_pkg::SCALE_EXP);
  wire         wr_ok     = bus.cmd_valid && bus.cmd_write && cmd_hit && !scale_bad;

  function automatic logic [15:0] reset_word(input int i);
    if (i == int'(pmbus_calc_pkg::IDX_SCALE)) begin
      reset_word = pmbus_calc_pkg::RST_SCALE;
    end else if (i == int'(pmbus_calc_pkg::IDX_RISE)) begin
      reset_word = pmbus_calc_pkg::RST_RISE;
    end else begin
      reset_word = pmbus_calc_pkg::RST_ZERO;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < pmbus_calc_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          regs_q[g] <= reset_word(g);
        end else if (wr_ok && (cmd_idx == 4'(g))) begin
          regs_q[g] <= bus.cmd_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
      rsp_err_q   <= 1'b0;
    end else begin
      rsp_valid_q <= bus.cmd_valid;
      rsp_rdata_q <= (bus.cmd_valid && !bus.cmd_write && cmd_hit) ? regs_q[cmd_idx] : 16'h0000;
      rsp_err_q   <= bus.cmd_valid && (!cmd_hit || (bus.cmd_write && scale_bad));
    end
  end

  assign bus.rsp_valid = rsp_valid_q;
  assign bus.rsp_rdata = rsp_rdata_q;
  assign bus.rsp_err   = rsp_err_q;

  //////////////////////////////////////////////////////////////////////////////
  // Feedback reference

  wire [15:0] scale_w = regs_q[pmbus_calc_pkg::IDX_SCALE];
  wire [1:0]  op_mrg  = regs_q[pmbus_calc_pkg::IDX_OP][pmbus_calc_pkg::OP_MARGIN_LSB +: 2];

  wire logic signed [63:0] trim_v = pmbus_calc_pkg::lin_to_q16(regs_q[pmbus_calc_pkg::IDX_TRIM]);
  wire logic signed [63:0] mhi_v  = pmbus_calc_pkg::lin_to_q16(regs_q[pmbus_calc_pkg::IDX_MHIGH]);
  wire logic signed [63:0] mlo_v  = pmbus_calc_pkg::lin_to_q16(regs_q[pmbus_calc_pkg::IDX_MLOW]);

  wire logic signed [63:0] trim_fb = pmbus_calc_pkg::clamp64(
      pmbus_calc_pkg::fb_of(trim_v, scale_w),
      -pmbus_calc_pkg::DEV_LIMIT_Q16, pmbus_calc_pkg::DEV_LIMIT_Q16);
  wire logic signed [63:0] vfb_none = trim_fb + pmbus_calc_pkg::BASE_REF_Q16;
  wire logic signed [63:0] vfb_high = pmbus_calc_pkg::fb_of(mhi_v + trim_v, scale_w);
  wire logic signed [63:0] vfb_low  = pmbus_calc_pkg::fb_of(mlo_v + trim_v, scale_w);

  wire logic signed [63:0] vfb_sel =
      (op_mrg == pmbus_calc_pkg::OP_MARGIN_HIGH) ? vfb_high :
      (op_mrg == pmbus_calc_pkg::OP_MARGIN_LOW)  ? vfb_low  : vfb_none;
  wire [1:0] state_d = (op_mrg == pmbus_calc_pkg::OP_MARGIN_HIGH ||
                        op_mrg == pmbus_calc_pkg::OP_MARGIN_LOW) ? op_mrg : 2'h0;

  // Deviation from base, clamped, then one step is 1/256 of 600 mV
  wire logic signed [63:0] dev_c = pmbus_calc_pkg::clamp64(
      vfb_sel - pmbus_calc_pkg::BASE_REF_Q16,
      -pmbus_calc_pkg::DEV_LIMIT_Q16, pmbus_calc_pkg::DEV_LIMIT_Q16);
  wire logic signed [63:0] code_w = pmbus_calc_pkg::clamp64(
      (dev_c * pmbus_calc_pkg::TRIM_CODE_K) >>> 16,
      pmbus_calc_pkg::TRIM_CODE_MIN, pmbus_calc_pkg::TRIM_CODE_MAX);
  wire logic signed [6:0] target = code_w[6:0];

  //////////////////////////////////////////////////////////////////////////////
  // Ramp between states

  // Soft-start covers 256 steps in the rise time, so one step per tss/256.
  // The FB slope does not depend on the scale ratio, only the output slope does.
  wire logic signed [63:0] rise_v = pmbus_calc_pkg::lin_to_q16(regs_q[pmbus_calc_pkg::IDX_RISE]);
  wire logic signed [63:0] per_w  = pmbus_calc_pkg::clamp64(
      (rise_v * 64'(pmbus_calc_pkg::CYCLES_PER_MS)) >>> pmbus_calc_pkg::RAMP_SHIFT,
      64'sd1, 64'sh0000_0000_00FF_FFFF);
  wire [23:0] step_period = per_w[23:0];

  logic [23:0]       ramp_cnt_q;
  logic signed [6:0] ref_q;
  wire               at_target = (ref_q == target);
  wire               step_now  = !at_target && (ramp_cnt_q + 24'h1 >= step_period);
  wire [23:0]        ramp_cnt_d = (at_target || step_now) ? 24'h0 : ramp_cnt_q + 24'h1;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ramp_cnt_q <= 24'h0;
      ref_q      <= 7'sh00;
    end else begin
      ramp_cnt_q <= ramp_cnt_d;
      if (step_now) begin
        ref_q <= (target > ref_q) ? ref_q + 7'sh01 : ref_q - 7'sh01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overcurrent thresholds

  wire logic signed [63:0] gain_code = pmbus_calc_pkg::clamp64(
      (pmbus_calc_pkg::lin_to_q16(regs_q[pmbus_calc_pkg::IDX_GAIN]) *
       pmbus_calc_pkg::GAIN_RECIP_K) >>> pmbus_calc_pkg::GAIN_RECIP_SH,
      64'sd0, pmbus_calc_pkg::GAIN_CODE_MAX);
  wire logic signed [63:0] r_mohm = gain_code * pmbus_calc_pkg::GAIN_STEP_Q16;
  wire logic signed [63:0] offs_code = pmbus_calc_pkg::clamp64(
      pmbus_calc_pkg::lin_to_q16(regs_q[pmbus_calc_pkg::IDX_OFFS]) >>> pmbus_calc_pkg::OFFS_SHIFT,
      -64'sd64, 64'sd63);
  wire logic signed [63:0] offs_a = offs_code <<< pmbus_calc_pkg::OFFS_SHIFT;
  wire logic signed [63:0] temp_f = pmbus_calc_pkg::ONE_Q16 + pmbus_calc_pkg::TEMPCO_Q16 *
                                    (64'(i_die_temp) - pmbus_calc_pkg::TEMP_REF_C);

  // Every operand is an argument, so the continuous assignments below wake on
  // temperature, gain and offset changes and not only on a new limit word
  function automatic logic [DAC_W-1:0] oc_dac(input logic [15:0]        lim_w,
                                             input logic signed [63:0] r_m,
                                             input logic signed [63:0] offs,
                                             input logic signed [63:0] tf);
    logic signed [63:0] lim;
    logic signed [63:0] amps;
    logic signed [63:0] mv;
    logic signed [63:0] code;
    lim  = (pmbus_calc_pkg::lin_to_q16(lim_w) >>> pmbus_calc_pkg::LIMIT_SHIFT)
           <<< pmbus_calc_pkg::LIMIT_SHIFT;
    amps = pmbus_calc_pkg::clamp64(lim - offs, 64'sd0, pmbus_calc_pkg::AMPS_MAX_Q16);
    mv   = ((amps * r_m) * tf) >>> 16;
    // Both quantisers apply, so the coarser one sets the granularity
    code = pmbus_calc_pkg::clamp64(
        (mv * pmbus_calc_pkg::DAC_RECIP_K) >>> pmbus_calc_pkg::DAC_SHIFT,
        64'sd0, DAC_MAX);
    oc_dac = code[DAC_W-1:0];
  endfunction

  wire [DAC_W-1:0] warn_d  = oc_dac(regs_q[pmbus_calc_pkg::IDX_WARN], r_mohm, offs_a, temp_f);
  wire [DAC_W-1:0] fault_d = oc_dac(regs_q[pmbus_calc_pkg::IDX_FAULT], r_mohm, offs_a, temp_f);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_oc_warn_dac  <= '0;
      o_oc_fault_dac <= '0;
      o_margin_state <= 2'h0;
      o_ramping      <= 1'b0;
    end else begin
      o_oc_warn_dac  <= warn_d;
      o_oc_fault_dac <= fault_d;
      o_margin_state <= state_d;
      o_ramping      <= !at_target;
    end
  end

  assign o_ref_code = ref_q;

endmodule

/* verilog/setpoint_threshold_host.sv */
`timescale 1ns/1ps
module setpoint_threshold_host #(
  parameter logic signed [63:0] MAX_OC_Q16 = 64'sh0000_0000_0014_0000
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // User request
  input  wire logic        i_req_valid,
  input  wire logic        i_req_write,
  input  wire logic [7:0]  i_req_code,
  input  wire logic [15:0] i_req_data,
  // User answer
  output logic             o_busy,
  output logic             o_done,
  output logic             o_err,
  output logic             o_refused,
  output logic [15:0]      o_rdata,
  // Device side
  pmbus_cfg_if.host_mp     bus
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } host_state_t;

  host_state_t state_q;
  logic        scale_set_q;
  logic        gain_set_q;
  logic        offs_set_q;
  logic [15:0] scale_w_q;
  logic [15:0] trim_w_q;
  logic        cmd_valid_q;
  logic        cmd_write_q;
  logic [7:0]  cmd_code_q;
  logic [15:0] cmd_wdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Ordering and range checks on writes

  wire [3:0] idx = pmbus_calc_pkg::code_index(i_req_code);
  wire is_adj   = (idx == pmbus_calc_pkg::IDX_TRIM) || (idx == pmbus_calc_pkg::IDX_MHIGH) ||
                  (idx == pmbus_calc_pkg::IDX_MLOW) || (idx == pmbus_calc_pkg::IDX_OP);
  wire is_limit = (idx == pmbus_calc_pkg::IDX_FAULT) || (idx == pmbus_calc_pkg::IDX_WARN);
  wire logic signed [63:0] req_v  = pmbus_calc_pkg::lin_to_q16(i_req_data);
  wire logic signed [63:0] trim_v = pmbus_calc_pkg::lin_to_q16(trim_w_q);
  wire logic signed [63:0] trim_fb = pmbus_calc_pkg::fb_of(req_v, scale_w_q);
  wire logic signed [63:0] mrg_dev = pmbus_calc_pkg::fb_of(req_v + trim_v, scale_w_q) -
                                     pmbus_calc_pkg::BASE_REF_Q16;
  wire trim_bad = (idx == pmbus_calc_pkg::IDX_TRIM) &&
                  ((trim_fb > pmbus_calc_pkg::DEV_LIMIT_Q16) ||
                   (trim_fb < -pmbus_calc_pkg::DEV_LIMIT_Q16));
  wire mrg_bad  = ((idx == pmbus_calc_pkg::IDX_MHIGH) || (idx == pmbus_calc_pkg::IDX_MLOW)) &&
                  ((mrg_dev > pmbus_calc_pkg::DEV_LIMIT_Q16) ||
                   (mrg_dev < -pmbus_calc_pkg::DEV_LIMIT_Q16));
  wire refuse   = i_req_write &&
                  ((is_adj && !scale_set_q) ||
                   (is_limit && !(gain_set_q && offs_set_q)) ||
                   (is_limit && (req_v > MAX_OC_Q16)) ||
                   trim_bad || mrg_bad);
  wire take     = (state_q == ST_IDLE) && i_req_valid;
  wire send     = take && !refuse;
  wire finish   = (state_q == ST_WAIT) && bus.rsp_valid;
  wire good_wr  = finish && cmd_write_q && !bus.rsp_err;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (send) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (bus.rsp_valid) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_valid_q <= 1'b0;
      cmd_write_q <= 1'b0;
      cmd_code_q  <= 8'h00;
      cmd_wdata_q <= 16'h0000;
    end else begin
      cmd_valid_q <= send;
      if (send) begin
        cmd_write_q <= i_req_write;
        cmd_code_q  <= i_req_code;
        cmd_wdata_q <= i_req_data;
      end
    end
  end

  // Progress flags only count writes the device acknowledged
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      scale_set_q <= 1'b0;
      gain_set_q  <= 1'b0;
      offs_set_q  <= 1'b0;
      scale_w_q   <= pmbus_calc_pkg::RST_SCALE;
      trim_w_q    <= pmbus_calc_pkg::RST_ZERO;
    end else if (good_wr) begin
      case (pmbus_calc_pkg::code_index(cmd_code_q))
        pmbus_calc_pkg::IDX_SCALE: begin
          scale_set_q <= 1'b1;
          scale_w_q   <= cmd_wdata_q;
        end
        pmbus_calc_pkg::IDX_TRIM: trim_w_q   <= cmd_wdata_q;
        pmbus_calc_pkg::IDX_GAIN: gain_set_q <= 1'b1;
        pmbus_calc_pkg::IDX_OFFS: offs_set_q <= 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_err     <= 1'b0;
      o_refused <= 1'b0;
      o_rdata   <= 16'h0000;
    end else begin
      o_busy    <= send || ((state_q == ST_WAIT) && !bus.rsp_valid);
      o_done    <= finish || (take && refuse);
      o_refused <= take && refuse;
      o_err     <= finish && bus.rsp_err;
      if (finish) begin
        o_rdata <= bus.rsp_rdata;
      end
    end
  end

  assign bus.cmd_valid = cmd_valid_q;
  assign bus.cmd_write = cmd_write_q;
  assign bus.cmd_code  = cmd_code_q;
  assign bus.cmd_wdata = cmd_wdata_q;

endmodule

/* verification/pmbus_cfg_asserts.sv */
`timescale 1ns/1ps
module pmbus_cfg_asserts (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  // Interface signals
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic        rsp_err
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic        scale_pend_q;
  logic        scale_ok_q;
  logic [1:0]  cal_q;
  logic [15:0] trim_q;
  wire         wr       = cmd_valid && cmd_write;
  wire         scale_wr = wr && (cmd_code == pmbus_calc_pkg::CMD_SCALE_LOOP);
  wire         trim_wr  = wr && (cmd_code == pmbus_calc_pkg::CMD_OUTPUT_TRIM);
  wire         oc_wr    = wr && (cmd_code == pmbus_calc_pkg::CMD_OC_WARN
                                 || cmd_code == pmbus_calc_pkg::CMD_OC_FAULT);
  // Shadow of host writes; only the scale flag waits for an acknowledge
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      scale_pend_q <= 1'b0;
      scale_ok_q   <= 1'b0;
      cal_q        <= 2'h0;
      trim_q       <= 16'h0000;
    end else begin
      scale_pend_q <= scale_wr;
      scale_ok_q   <= scale_ok_q | (scale_pend_q && rsp_valid && !rsp_err);
      cal_q[0]     <= cal_q[0] | (wr && cmd_code == pmbus_calc_pkg::CMD_SENSE_GAIN);
      cal_q[1]     <= cal_q[1] | (wr && cmd_code == pmbus_calc_pkg::CMD_SENSE_OFFS);
      trim_q       <= trim_wr ? cmd_wdata : trim_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid)
    else $error("answer missing one cycle after command");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  AST_RSP_QUIET: assert property (!rsp_valid |-> rsp_rdata == 16'h0000 && !rsp_err)
    else $error("response lines busy while idle");
  AST_SCALE_BAD: assert property (
    scale_wr && cmd_wdata[15:11] != pmbus_calc_pkg::SCALE_EXP |=> rsp_err)
    else $error("scale word with wrong exponent accepted");
  AST_SCALE_GOOD: assert property (
    scale_wr && cmd_wdata[15:11] == pmbus_calc_pkg::SCALE_EXP |=> !rsp_err)
    else $error("scale word with fixed exponent refused");
  AST_RD_TRIM: assert property (
    cmd_valid && !cmd_write && cmd_code == pmbus_calc_pkg::CMD_OUTPUT_TRIM
    |=> rsp_rdata == trim_q && !rsp_err)
    else $error("trim read back differs from last write");
  AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid ##1 !cmd_valid)
    else $error("host command not a single pulse");
  AST_TRIM_ORDER: assert property (trim_wr |-> scale_ok_q)
    else $error("trim sent before scale acknowledged");
  AST_OC_ORDER: assert property (oc_wr |-> cal_q == 2'h3)
    else $error("current limit sent before gain and offset");
  COV_BAD_SCALE: cover property (scale_wr ##1 rsp_err);
  COV_MARGIN: cover property (wr && cmd_code == pmbus_calc_pkg::CMD_OPERATION);
  COV_OC: cover property (oc_wr ##1 rsp_valid);
endmodule

/* verification/setpoint_threshold_tb.sv */
`timescale 1ns/1ps
module setpoint_threshold_tb;
  typedef struct packed {
    logic w; logic [7:0] code; logic [15:0] data; logic err; logic refd; logic [15:0] rd;
  } row_t;
  logic              i_clk_sys   = 1'b0;
  logic              i_resetn    = 1'b0;
  logic              i_req_valid = 1'b0;
  logic              i_req_write = 1'b0;
  logic [7:0]        i_req_code  = 8'h00;
  logic [15:0]       i_req_data  = 16'h0000;
  logic signed [7:0] i_die_temp  = 8'h19;
  logic              o_busy, o_done, o_err, o_refused, o_ramping;
  logic [15:0]       o_rdata;
  logic signed [6:0] o_ref_code;
  logic [1:0]        o_margin_state;
  logic [7:0]        o_oc_warn_dac, o_oc_fault_dac;
  int                fails = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                n;
  row_t rows [17] = '{
    '{1'b0, 8'h29, 16'h0000, 1'b0, 1'b0, 16'hB900}, '{1'b1, 8'h22, 16'hF001, 1'b0, 1'b1, 16'h0000},
    '{1'b1, 8'h61, 16'h0000, 1'b0, 1'b0, 16'h0000}, '{1'b1, 8'h29, 16'hB900, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 8'h29, 16'hC100, 1'b1, 1'b0, 16'h0000}, '{1'b0, 8'h29, 16'h0000, 1'b0, 1'b0, 16'hB900},
    '{1'b1, 8'h22, 16'hF001, 1'b0, 1'b0, 16'h0000}, '{1'b0, 8'h22, 16'h0000, 1'b0, 1'b0, 16'hF001},
    '{1'b1, 8'h22, 16'hF002, 1'b0, 1'b1, 16'h0000}, '{1'b1, 8'h4A, 16'h000A, 1'b0, 1'b1, 16'h0000},
    '{1'b1, 8'h38, 16'h0004, 1'b0, 1'b0, 16'h0000}, '{1'b1, 8'h39, 16'h0000, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 8'h4A, 16'h000A, 1'b0, 1'b0, 16'h0000}, '{1'b1, 8'h46, 16'h001E, 1'b0, 1'b1, 16'h0000},
    '{1'b0, 8'h00, 16'h0000, 1'b1, 1'b0, 16'h0000}, '{1'b1, 8'h25, 16'h0001, 1'b0, 1'b0, 16'h0000},
    '{1'b1, 8'h26, 16'hF003, 1'b0, 1'b0, 16'h0000}};
  // Operation word, expected margin state, expected reference code
  logic [15:0] op_w [3] = '{16'h0020, 16'h0010, 16'h0000};
  logic [1:0]  op_s [3] = '{2'h2, 2'h1, 2'h0};
  logic [6:0]  op_c [3] = '{7'h0A, 7'h55, 7'h35};

  pmbus_cfg_if i_pmbus_cfg_if ();
  setpoint_threshold_host i_setpoint_threshold_host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_code(i_req_code),
    .i_req_data(i_req_data), .o_busy(o_busy), .o_done(o_done), .o_err(o_err),
    .o_refused(o_refused), .o_rdata(o_rdata), .bus(i_pmbus_cfg_if.host_mp));
  setpoint_threshold_dev i_setpoint_threshold_dev (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .bus(i_pmbus_cfg_if.dev_mp), .i_die_temp(i_die_temp), .o_ref_code(o_ref_code),
    .o_ramping(o_ramping), .o_margin_state(o_margin_state), .o_oc_warn_dac(o_oc_warn_dac),
    .o_oc_fault_dac(o_oc_fault_dac));
  pmbus_cfg_asserts i_pmbus_cfg_asserts (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .cmd_valid(i_pmbus_cfg_if.cmd_valid), .cmd_write(i_pmbus_cfg_if.cmd_write),
    .cmd_code(i_pmbus_cfg_if.cmd_code), .cmd_wdata(i_pmbus_cfg_if.cmd_wdata),
    .rsp_valid(i_pmbus_cfg_if.rsp_valid), .rsp_rdata(i_pmbus_cfg_if.rsp_rdata),
    .rsp_err(i_pmbus_cfg_if.rsp_err));

  always #50 i_clk_sys = ~i_clk_sys;
  // Whole run needs well under two thousand cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic req(input row_t r);
    int k;
    k = 0;
    @(posedge i_clk_sys);
    i_req_valid <= 1'b1;
    i_req_write <= r.w;
    i_req_code  <= r.code;
    i_req_data  <= r.data;
    @(posedge i_clk_sys);
    i_req_valid <= 1'b0;
    @(negedge i_clk_sys);
    check({15'h0, o_busy}, {15'h0, !r.refd});
    while (o_done !== 1'b1 && k < 10) begin
      @(negedge i_clk_sys);
      k++;
    end
    check({15'h0, o_done}, 16'h0001);
    check({15'h0, o_busy}, 16'h0000);
    check({15'h0, o_err}, {15'h0, r.err});
    check({15'h0, o_refused}, {15'h0, r.refd});
    if (!r.w)
      check(o_rdata, r.rd);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    foreach (rows[i])
      req(rows[i]);
    for (int m = 0; m < 3; m++) begin
      req('{1'b1, 8'h01, op_w[m], 1'b0, 1'b0, 16'h0000});
      check({15'h0, o_ramping}, 16'h0001);
      n = 0;
      while ((o_ramping !== 1'b0 || o_ref_code !== op_c[m]) && n < 300) begin
        @(negedge i_clk_sys);
        n++;
      end
      check({14'h0, o_margin_state}, {14'h0, op_s[m]});
      check({9'h0, o_ref_code}, {9'h0, op_c[m]});
    end
    check({8'h00, o_oc_warn_dac}, 16'h0015);
    check({8'h00, o_oc_fault_dac}, 16'h0000);
    // 20 A sits exactly on the host ceiling, so it must go through
    req('{1'b1, 8'h46, 16'h0014, 1'b0, 1'b0, 16'h0000});
    @(negedge i_clk_sys);
    check({8'h00, o_oc_fault_dac}, 16'h002A);
    @(posedge i_clk_sys);
    i_die_temp <= 8'h7D;
    repeat (4) @(negedge i_clk_sys);
    check({8'h00, o_oc_warn_dac}, 16'h001D);
    check({8'h00, o_oc_fault_dac}, 16'h003B);
    // Half a millisecond of rise time gives one code step every 19 cycles
    req('{1'b1, 8'h61, 16'hF801, 1'b0, 1'b0, 16'h0000});
    req('{1'b1, 8'h01, 16'h0020, 1'b0, 1'b0, 16'h0000});
    n = 0;
    while (o_ref_code === 7'h35 && n < 300) begin
      @(negedge i_clk_sys);
      n++;
    end
    n = 0;
    while (o_ref_code === 7'h34 && n < 300) begin
      @(negedge i_clk_sys);
      n++;
    end
    check(16'(n), 16'h0013);
    // Reset in mid-run must drop the reference code, margin state and warn DAC
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    @(negedge i_clk_sys);
    check({9'h0, o_ref_code}, 16'h0000);
    check({6'h0, o_margin_state, o_oc_warn_dac}, 16'h0000);
    @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    req('{1'b0, 8'h22, 16'h0000, 1'b0, 1'b0, 16'h0000});
    req('{1'b1, 8'h22, 16'hF001, 1'b0, 1'b1, 16'h0000});
    end_sim();
  end
endmodule
